// ===== scp_defs.svh
// Register addresses, field positions, reset values and serial framing constants
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH

// ==========================================================
// Register addresses (13-bit serial address space)
`define SCP_ADDR_CFG    13'h0000
`define SCP_ADDR_PID    13'h0003
`define SCP_ADDR_RBS    13'h0004
`define SCP_ADDR_PDS    13'h0230
`define SCP_ADDR_RSV    13'h0231
`define SCP_ADDR_UPD    13'h0232
`define SCP_ADDR_STEP   13'h0001

// ==========================================================
// Reset values
`define SCP_CFG_RST     8'h18
`define SCP_RBS_RST     8'h00
`define SCP_PDS_RST     8'h00
`define SCP_ZERO_BYTE   8'h00

// ==========================================================
// Field positions
`define SCP_BIT_SDO_ACT 0
`define SCP_BIT_LSB     1
`define SCP_BIT_SRST    2
`define SCP_BIT_RBSEL   0
`define SCP_BIT_UPD     0
`define SCP_INS_RW      15
`define SCP_INS_LEN_HI  14
`define SCP_INS_LEN_LO  13
`define SCP_INS_ADR_HI  12

// ==========================================================
// Serial framing
`define SCP_INSTR_LAST  4'hF
`define SCP_BYTE_LAST   4'h7
`define SCP_CNT_ZERO    4'h0
`define SCP_CNT_STEP    4'h1
`define SCP_LEN_STREAM  2'h3
`define SCP_LEFT_ZERO   2'h0
`define SCP_LEFT_STEP   2'h1

`endif

// ===== scp_pkg.sv
// Types shared by the serial port configuration register block
package scp_pkg;

	// ==========================================================
	// Serial transaction states
	typedef enum logic [1:0]
	{
		SCP_IDLE  = 2'b00,
		SCP_INSTR = 2'b01,
		SCP_XFER  = 2'b10,
		SCP_DONE  = 2'b11
	} scp_state_t;

endpackage

// ===== scp_reg_bank.sv
// Register storage, buffered/active PDS pair, update strobe and readback mux
`timescale 1ns/10ps
`default_nettype none
`include "scp_defs.svh"

module scp_reg_bank
	import scp_pkg::*;
#(
	parameter logic [7:0] VARIANT_IDENTIFIER = 8'h5A // Arbitrary variant code
)
(
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	// Write port
	input  wire logic        wr_en_i,
	input  wire logic [12:0] wr_addr_i,
	input  wire logic [7:0]  wr_data_i,
	// Read port
	input  wire logic [12:0] rd_addr_i,
	output logic      [7:0]  rd_data_o,
	// Register contents
	output logic      [7:0]  cfg_o,
	output logic      [7:0]  pds_active_o
);

	// ==========================================================
	// Address decode
	function automatic logic hit(input logic [12:0] a, input logic [12:0] t);
		hit = (a == t);
	endfunction

	logic [7:0] cfg_q, cfg_d;
	logic       rbs_q, rbs_d;
	logic [7:0] pds_buf_q, pds_buf_d;
	logic [7:0] pds_act_q, pds_act_d;
	logic       upd_q, upd_d;
	logic       srst;

	// Whole reset byte, so its select bit can be picked out by field position
	localparam logic [7:0] RBS_RST = `SCP_RBS_RST;

	assign srst = cfg_q[`SCP_BIT_SRST];

	// Next values; soft reset holds everything but the config register
	always_comb
	begin
		cfg_d     = cfg_q;
		rbs_d     = rbs_q;
		pds_buf_d = pds_buf_q;
		pds_act_d = pds_act_q;
		upd_d     = 1'b0;                                   // Self-clearing
		if (wr_en_i && hit(wr_addr_i, `SCP_ADDR_CFG))
			cfg_d = wr_data_i;                              // Reset bit stays until rewritten
		if (srst)
		begin
			rbs_d     = RBS_RST[`SCP_BIT_RBSEL];            // Defaults while held
			pds_buf_d = `SCP_PDS_RST;
			pds_act_d = `SCP_PDS_RST;
		end
		else
		begin
			if (upd_q)
				pds_act_d = pds_buf_q;                      // Buffered PDS value applied
			if (wr_en_i && hit(wr_addr_i, `SCP_ADDR_RBS))
				rbs_d = wr_data_i[`SCP_BIT_RBSEL];
			if (wr_en_i && hit(wr_addr_i, `SCP_ADDR_PDS))
				pds_buf_d = wr_data_i;
			if (wr_en_i && hit(wr_addr_i, `SCP_ADDR_UPD))
				upd_d = wr_data_i[`SCP_BIT_UPD];            // Update trigger
		end
	end

	// Register stage
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cfg_q     <= `SCP_CFG_RST;
			rbs_q     <= RBS_RST[`SCP_BIT_RBSEL];
			pds_buf_q <= `SCP_PDS_RST;
			pds_act_q <= `SCP_PDS_RST;
			upd_q     <= 1'b0;
		end
		else
		begin
			cfg_q     <= cfg_d;
			rbs_q     <= rbs_d;
			pds_buf_q <= pds_buf_d;
			pds_act_q <= pds_act_d;
			upd_q     <= upd_d;
		end
	end

	// Readback; unmapped and reserved addresses read zero
	always_comb
	begin
		rd_data_o = `SCP_ZERO_BYTE;
		if (hit(rd_addr_i, `SCP_ADDR_CFG))
			rd_data_o = cfg_q;
		else if (hit(rd_addr_i, `SCP_ADDR_PID))
			rd_data_o = VARIANT_IDENTIFIER;                            // Fixed, writes ignored
		else if (hit(rd_addr_i, `SCP_ADDR_RBS))
			rd_data_o = {7'h00, rbs_q};
		else if (hit(rd_addr_i, `SCP_ADDR_PDS))
			rd_data_o = rbs_q ? pds_act_q : pds_buf_q;      // Bank select
		else if (hit(rd_addr_i, `SCP_ADDR_UPD))
			rd_data_o = {7'h00, upd_q};
	end

	assign cfg_o        = cfg_q;
	assign pds_active_o = pds_act_q;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	a_srst_defaults: assert property (srst |=> (pds_buf_q == `SCP_PDS_RST) && !rbs_q)
		else $error("soft reset did not restore defaults");
	a_srst_sticky: assert property (srst && !(wr_en_i && hit(wr_addr_i, `SCP_ADDR_CFG))
		|=> srst)
		else $error("soft reset bit cleared itself");
	a_pid_fixed: assert property (hit(rd_addr_i, `SCP_ADDR_PID) |-> rd_data_o == VARIANT_IDENTIFIER)
		else $error("identifier read wrong");
	a_rb_select: assert property (hit(rd_addr_i, `SCP_ADDR_PDS)
		|-> rd_data_o == (rbs_q ? pds_act_q : pds_buf_q))
		else $error("readback bank wrong");
	a_upd_selfclear: assert property (wr_en_i && hit(wr_addr_i, `SCP_ADDR_UPD)
		&& wr_data_i[`SCP_BIT_UPD] && !srst |=> upd_q ##1 !upd_q)
		else $error("update strobe not one cycle");
	a_upd_copy: assert property (upd_q && !srst |=> pds_act_q == $past(pds_buf_q))
		else $error("active register not updated");

endmodule // scp_reg_bank
`default_nettype wire

// ===== scp_config_regs.sv
// Serial control port engine with configuration and system control registers
// Function
// - Only 16-bit instructions exist; host keeps long-instruction bit at one.
// - Soft reset bit restores defaults, stays set until host writes zero.
// - Bit order zero: MSB first, address decrements; one: LSB first, increments.
// - Mode zero: reads on data pin, output pin high-Z; one: reads on output pin.
// - Read-only 8-bit variant identifier; writes ignored.
// - Readback select zero returns buffered values, one returns active values.
// - Writing one to update bit triggers update; bit clears by itself.
`timescale 1ns/10ps
`default_nettype none
`include "scp_defs.svh"

module scp_config_regs
	import scp_pkg::*;
#(
	parameter logic [7:0] VARIANT_IDENTIFIER = 8'h5A // Arbitrary variant code
)
(
	// Clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	// Serial control port
	input  wire logic       sclk_i,
	input  wire logic       cs_n_i,
	input  wire logic       sdio_i,
	output logic            sdio_o,
	output logic            sdio_oe_n_o,
	output logic            serial_data_output_pin_o,
	output logic            serial_data_output_pin_oe_n_o,
	// Configuration state
	output logic            soft_reset_o,
	output logic            lsb_first_o,
	output logic            sdo_active_o,
	output logic [7:0]      pds_active_o
);

	// ==========================================================
	// Bit shifting in either order
	function automatic logic [15:0] shift_in(input logic [15:0] s, input logic b,
		input logic lsb);
		shift_in = lsb ? {b, s[15:1]} : {s[14:0], b};
	endfunction

	logic [7:0]  cfg;
	logic        lsb, sdo_act;
	logic        sclk_q, rise, fall;
	scp_state_t  st_q, st_d;
	logic [3:0]  bit_q, bit_d;
	logic [15:0] sr_q, sr_d, sr_n;
	logic        rw_q, rw_d;
	logic [1:0]  len_q, len_d;
	logic [1:0]  left_q, left_d;
	logic [12:0] addr_q, addr_d, addr_step;
	logic [7:0]  rd_q, rd_d;
	logic        drv_q, drv_d;
	logic        wr_en_q, wr_en_d;
	logic [12:0] wr_addr_q, wr_addr_d;
	logic [7:0]  wr_data_q, wr_data_d;
	logic [7:0]  rd_data;
	logic        byte_end;

	assign lsb     = cfg[`SCP_BIT_LSB];
	assign sdo_act = cfg[`SCP_BIT_SDO_ACT];

	// ==========================================================
	// Register storage
	scp_reg_bank #(
		.VARIANT_IDENTIFIER (VARIANT_IDENTIFIER)
	) u_bank (
		.mclk_i       (mclk_i),
		.rst_n_i      (rst_n_i),
		.wr_en_i      (wr_en_q),
		.wr_addr_i    (wr_addr_q),
		.wr_data_i    (wr_data_q),
		.rd_addr_i    (addr_q),
		.rd_data_o    (rd_data),
		.cfg_o        (cfg),
		.pds_active_o (pds_active_o)
	);

	// ==========================================================
	// Serial clock edges, taken from the sampled pin level
	assign rise      = sclk_i && !sclk_q;
	assign fall      = !sclk_i && sclk_q;
	assign sr_n      = shift_in(sr_q, sdio_i, lsb);             // Writes always on data pin
	assign addr_step = lsb ? addr_q + `SCP_ADDR_STEP
	                       : addr_q - `SCP_ADDR_STEP;           // Stepping direction
	assign byte_end  = rise && (bit_q == `SCP_BYTE_LAST);

	// Transaction sequencing next values
	always_comb
	begin
		st_d      = st_q;
		bit_d     = bit_q;
		sr_d      = sr_q;
		rw_d      = rw_q;
		len_d     = len_q;
		left_d    = left_q;
		addr_d    = addr_q;
		rd_d      = rd_q;
		drv_d     = drv_q;
		wr_en_d   = 1'b0;
		wr_addr_d = wr_addr_q;
		wr_data_d = wr_data_q;
		if (cs_n_i)
		begin
			// Chip select high aborts any frame
			st_d  = SCP_IDLE;
			drv_d = 1'b0;
		end
		else
		begin
			case (st_q)
				SCP_IDLE:
				begin
					st_d  = SCP_INSTR;
					bit_d = `SCP_CNT_ZERO;
				end
				SCP_INSTR:
				begin
					if (rise)
					begin
						sr_d  = sr_n;
						bit_d = bit_q + `SCP_CNT_STEP;
						// Length bit ignored: instruction is always 16 bits
						if (bit_q == `SCP_INSTR_LAST)
						begin
							st_d   = SCP_XFER;
							bit_d  = `SCP_CNT_ZERO;
							rw_d   = sr_n[`SCP_INS_RW];
							len_d  = sr_n[`SCP_INS_LEN_HI:`SCP_INS_LEN_LO];
							left_d = sr_n[`SCP_INS_LEN_HI:`SCP_INS_LEN_LO];
							addr_d = sr_n[`SCP_INS_ADR_HI:0];
						end
					end
				end
				SCP_XFER:
				begin
					// Read byte loaded on the falling edge that opens it
					if (rw_q && fall)
					begin
						if (bit_q == `SCP_CNT_ZERO)
						begin
							rd_d  = rd_data;
							drv_d = 1'b1;
						end
						else
							rd_d = lsb ? {1'b0, rd_q[7:1]} : {rd_q[6:0], 1'b0};
					end
					if (rise)
					begin
						sr_d  = sr_n;
						bit_d = bit_q + `SCP_CNT_STEP;
					end
					if (byte_end)
					begin
						bit_d  = `SCP_CNT_ZERO;
						addr_d = addr_step;
						if (!rw_q)
						begin
							wr_en_d   = 1'b1;
							wr_addr_d = addr_q;
							wr_data_d = lsb ? sr_n[15:8] : sr_n[7:0];
						end
						if (len_q != `SCP_LEN_STREAM)
						begin
							if (left_q == `SCP_LEFT_ZERO)
								st_d = SCP_DONE;
							else
								left_d = left_q - `SCP_LEFT_STEP;
						end
					end
				end
				SCP_DONE:
				begin
					// Extra clocks are ignored until chip select rises
					drv_d = 1'b0;
				end
				default:
					st_d = SCP_IDLE;
			endcase
		end
	end

	// Transaction sequencing registers
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sclk_q    <= 1'b0;
			st_q      <= SCP_IDLE;
			bit_q     <= `SCP_CNT_ZERO;
			sr_q      <= 16'h0000;
			rw_q      <= 1'b0;
			len_q     <= 2'h0;
			left_q    <= 2'h0;
			addr_q    <= 13'h0000;
			rd_q      <= 8'h00;
			drv_q     <= 1'b0;
			wr_en_q   <= 1'b0;
			wr_addr_q <= 13'h0000;
			wr_data_q <= 8'h00;
		end
		else
		begin
			sclk_q    <= sclk_i;
			st_q      <= st_d;
			bit_q     <= bit_d;
			sr_q      <= sr_d;
			rw_q      <= rw_d;
			len_q     <= len_d;
			left_q    <= left_d;
			addr_q    <= addr_d;
			rd_q      <= rd_d;
			drv_q     <= drv_d;
			wr_en_q   <= wr_en_d;
			wr_addr_q <= wr_addr_d;
			wr_data_q <= wr_data_d;
		end
	end

	// ==========================================================
	// Pin drivers; output pin stays released in bidirectional mode
	assign sdio_o                        = lsb ? rd_q[0] : rd_q[7];
	assign serial_data_output_pin_o      = lsb ? rd_q[0] : rd_q[7];
	assign sdio_oe_n_o                   = !(drv_q && !sdo_act);
	assign serial_data_output_pin_oe_n_o = !(drv_q && sdo_act);

	// Configuration state straight from the register flops
	assign soft_reset_o = cfg[`SCP_BIT_SRST];
	assign lsb_first_o  = lsb;
	assign sdo_active_o = sdo_act;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_byte_close;
		st_q == SCP_XFER && !cs_n_i && byte_end;
	endsequence

	sequence s_instr_bit;
		st_q == SCP_INSTR && !cs_n_i && rise;
	endsequence

	a_instr_long: assert property (s_instr_bit ##0 (bit_q != `SCP_INSTR_LAST)
		|=> st_q == SCP_INSTR)
		else $error("instruction ended before 16 bits");
	a_instr_end: assert property (s_instr_bit ##0 (bit_q == `SCP_INSTR_LAST)
		|=> st_q == SCP_XFER && bit_q == `SCP_CNT_ZERO)
		else $error("instruction did not end at 16 bits");
	a_addr_incr: assert property (s_byte_close ##0 lsb
		|=> addr_q == $past(addr_q) + `SCP_ADDR_STEP)
		else $error("address did not increment");
	a_addr_decr: assert property (s_byte_close ##0 !lsb
		|=> addr_q == $past(addr_q) - `SCP_ADDR_STEP)
		else $error("address did not decrement");
	// Enables may trail chip select by one cycle, so the select is checked one edge back
	a_sdo_release: assert property (!serial_data_output_pin_oe_n_o
		|-> rw_q && sdo_act && !$past(cs_n_i))
		else $error("output pin driven outside a unidirectional read");
	a_sdio_read_only: assert property (!sdio_oe_n_o
		|-> rw_q && !sdo_act && !$past(cs_n_i))
		else $error("data pin driven outside a read");

endmodule // scp_config_regs
`default_nettype wire

// ===== scp_host_model.sv
// Host controller model driving the serial control port of the register block
`timescale 1ns/10ps
`default_nettype none

module scp_host_model
(
	// Clock
	input  wire logic mclk_i,
	// Device pins
	input  wire logic sdio_pin_i,
	input  wire logic sdio_oe_n_i,
	input  wire logic sdo_pin_i,
	input  wire logic sdo_oe_n_i,
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      sdio_o
);
	// ==========================================================
	// Data line level
	logic drv_q;
	logic last_q;

	// Released line shows the inverse of the last bit, so a stale value never matches
	assign sdio_o = !sdio_oe_n_i ? sdio_pin_i : (drv_q ? last_q : ~last_q);

	// Idle levels: clock low, deselected
	initial
	begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		drv_q  = 1'b1;
		last_q = 1'b0;
	end

	// ==========================================================
	// One serial clock period of 8 mclk; read bit taken just before the rise
	task automatic bit_cycle(input logic b, input logic dr, input logic serial_data_output_pin, output logic r);
		sclk_o = 1'b0;
		drv_q  = dr;
		if (dr)
			last_q = b;
		repeat (4) @(negedge mclk_i);
		r = serial_data_output_pin ? (sdo_oe_n_i ? ~sdo_pin_i : sdo_pin_i) : sdio_o;
		sclk_o = 1'b1;
		repeat (4) @(negedge mclk_i);
	endtask

	// Frame of n bytes, byte k in bits [8k+7:8k]; n above three streams three bytes
	task automatic frame(input logic rd, input int n, input logic [12:0] a, input logic lsb,
		input logic serial_data_output_pin, input logic [23:0] wd, output logic [23:0] rdat);
		logic [15:0] w;
		logic        r;
		w = {rd, (n > 3) ? 2'h3 : 2'(n - 1), a};
		rdat = 24'h000000;
		cs_n_o = 1'b0;
		repeat (2) @(negedge mclk_i);
		for (int i = 0; i < 16; i++)
			bit_cycle(lsb ? w[i] : w[15 - i], 1'b1, serial_data_output_pin, r);
		for (int k = 0; k < 8 * ((n > 3) ? 3 : n); k++)
		begin
			bit_cycle(wd[8 * (k / 8) + (lsb ? k % 8 : 7 - k % 8)], !rd, serial_data_output_pin, r);
			rdat[8 * (k / 8) + (lsb ? k % 8 : 7 - k % 8)] = r;
		end
		sclk_o = 1'b0;
		repeat (2) @(negedge mclk_i);
		cs_n_o = 1'b1;
		drv_q = 1'b1;
		repeat (4) @(negedge mclk_i);
	endtask
endmodule // scp_host_model

`default_nettype wire

// ===== scp_config_regs_test.sv
// Self-checking testbench for the serial port configuration register block
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) \
	begin \
		comparisons++; \
		if ((g) !== (e)) \
			begin \
			err_count++; \
			$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
			end \
	end

module scp_config_regs_test;
	localparam logic [7:0] VARIANT = 8'h3C; // Arbitrary variant code

	// ==========================================================
	// Signals and reference model state
	logic        mclk_i;
	logic        rst_n_i;
	logic        sclk;
	logic        cs_n;
	logic        sdio_in;
	logic        sdio_out;
	logic        sdio_oe_n;
	logic        sdo_pin;
	logic        sdo_oe_n;
	logic        soft_reset;
	logic        lsb_first;
	logic        sdo_active;
	logic [7:0]  pds_active;
	logic [7:0]  m_cfg;
	logic [7:0]  m_rbs;
	logic [7:0]  m_buf;
	logic [7:0]  m_act;
	logic [7:0]  v;
	logic [23:0] rdat;
	int          err_count;
	int          comparisons;
	int          cyc = 0;

	scp_config_regs #(.VARIANT_IDENTIFIER(VARIANT)) u_scp_config_regs
	(
		.mclk_i                        (mclk_i),
		.rst_n_i                       (rst_n_i),
		.sclk_i                        (sclk),
		.cs_n_i                        (cs_n),
		.sdio_i                        (sdio_in),
		.sdio_o                        (sdio_out),
		.sdio_oe_n_o                   (sdio_oe_n),
		.serial_data_output_pin_o      (sdo_pin),
		.serial_data_output_pin_oe_n_o (sdo_oe_n),
		.soft_reset_o                  (soft_reset),
		.lsb_first_o                   (lsb_first),
		.sdo_active_o                  (sdo_active),
		.pds_active_o                  (pds_active)
	);

	scp_host_model u_scp_host_model
	(
		.mclk_i      (mclk_i),
		.sdio_pin_i  (sdio_out),
		.sdio_oe_n_i (sdio_oe_n),
		.sdo_pin_i   (sdo_pin),
		.sdo_oe_n_i  (sdo_oe_n),
		.sclk_o      (sclk),
		.cs_n_o      (cs_n),
		.sdio_o      (sdio_in)
	);

	// Clock, 10 ns period
	initial
	begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	// Hang guard; the full run needs roughly a third of this
	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			err_count++;
			report_and_stop();
		end
	end

	// ==========================================================
	// Reference model
	function automatic logic [7:0] exp_rd(input logic [12:0] a);
		case (a)
			13'h0000: exp_rd = m_cfg;
			13'h0003: exp_rd = VARIANT;
			13'h0004: exp_rd = m_rbs;
			13'h0230: exp_rd = m_rbs[0] ? m_act : m_buf;
			default:  exp_rd = 8'h00;
		endcase
	endfunction

	// Soft reset holds the other registers at defaults while set
	task automatic mdl_wr(input logic [12:0] a, input logic [7:0] d);
		case (a)
			13'h0000: m_cfg = d;
			13'h0004: m_rbs = {7'h00, d[0]};
			13'h0230: m_buf = d;
			13'h0232: if (d[0]) m_act = m_buf;
			default: ;
		endcase
		if (m_cfg[2])
		begin
			m_rbs = 8'h00;
			m_buf = 8'h00;
			m_act = 8'h00;
		end
	endtask

	// One frame through the host, then every read byte and the state pins compared
	task automatic xfer(input logic rd, input int n, input logic [12:0] a, input logic [23:0] wd);
		logic [12:0] p;
		logic        lsb;
		lsb = m_cfg[1];
		u_scp_host_model.frame(rd, n, a, lsb, m_cfg[0], wd, rdat);
		p = a;
		for (int k = 0; k < ((n > 3) ? 3 : n); k++)
		begin
			if (rd)
				`CHK(rdat[8 * k +: 8], exp_rd(p))
			else
				mdl_wr(p, wd[8 * k +: 8]);
			p = lsb ? p + 13'h0001 : p - 13'h0001;
		end
		`CHK({soft_reset, lsb_first, sdo_active}, m_cfg[2:0])
		`CHK(pds_active, m_act)
		`CHK({sdio_oe_n, sdo_oe_n}, 2'b11)
	endtask

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		rst_n_i = 1'b0;
		m_cfg = 8'h18;
		m_rbs = 8'h00;
		m_buf = 8'h00;
		m_act = 8'h00;
		err_count = 0;
		comparisons = 0;
		void'($urandom(85));
		repeat (6) @(negedge mclk_i);
		rst_n_i = 1'b1;
		@(negedge mclk_i);
		// Defaults, identifier, decrementing address
		xfer(1'b1, 3, 13'h0004, 24'h000000);
		xfer(1'b1, 4, 13'h0004, 24'h000000);
		xfer(1'b0, 1, 13'h0003, 24'h0000FF);
		xfer(1'b1, 2, 13'h0003, 24'h000000);
		// Buffered against active copies, update strobe
		for (int i = 0; i < 3; i++)
		begin
			v = 8'($urandom);
			xfer(1'b0, 1, 13'h0230, {16'h0000, v});
			xfer(1'b1, 1, 13'h0230, 24'h000000);
			xfer(1'b0, 1, 13'h0004, 24'h000001);
			xfer(1'b1, 1, 13'h0230, 24'h000000);
			xfer(1'b0, 2, 13'h0232, 24'h000001);
			xfer(1'b1, 2, 13'h0232, 24'h000000);
			xfer(1'b1, 1, 13'h0230, 24'h000000);
			xfer(1'b0, 1, 13'h0004, 24'h000000);
		end
		// LSB first with mirrored nibbles, incrementing address
		xfer(1'b0, 1, 13'h0000, 24'h00005A);
		xfer(1'b1, 2, 13'h0003, 24'h000000);
		v = 8'($urandom);
		xfer(1'b0, 3, 13'h0230, {8'h01, 8'h00, v});
		// Reads on the separate output pin
		xfer(1'b0, 1, 13'h0000, 24'h0000DB);
		xfer(1'b1, 3, 13'h0230, 24'h000000);
		// Soft reset holds defaults until written back to zero
		xfer(1'b0, 1, 13'h0000, 24'h00003C);
		xfer(1'b0, 1, 13'h0004, 24'h000001);
		xfer(1'b1, 2, 13'h0004, 24'h000000);
		xfer(1'b0, 1, 13'h0000, 24'h000018);
		xfer(1'b0, 1, 13'h0230, 24'h000077);
		xfer(1'b1, 1, 13'h0230, 24'h000000);
		report_and_stop();
	end
endmodule // scp_config_regs_test

`default_nettype wire
